/* pllcfg_map.svh */
`ifndef PLLCFG_MAP_SVH
`define PLLCFG_MAP_SVH
// register byte offsets on the wishbone bus
`define PLLCFG_CTRL_OFS     8'h00
`define PLLCFG_REFDIV_OFS   8'h04
`define PLLCFG_FBDIV_OFS    8'h08
`define PLLCFG_AUXFB_OFS    8'h0c
`define PLLCFG_PRE2_OFS     8'h10
`define PLLCFG_FB2_OFS      8'h14
`define PLLCFG_STAT_OFS     8'h18
`define PLLCFG_OUTDIV_OFS   8'h20
// control register field positions
`define PLLCFG_BYPASS_BIT   0
`define PLLCFG_SRCSEL_LSB   1
`define PLLCFG_HALVE_BIT    3
`define PLLCFG_DBL_BIT      4
`define PLLCFG_ROUTE_BIT    5
`define PLLCFG_CENTER_BIT   6
`define PLLCFG_GUARD_BIT    7
`define PLLCFG_EXTH_BIT     8
`define PLLCFG_INDIV_LSB    9
`define PLLCFG_MANSEL_BIT   11
// reset values: only centering set after start-up
`define PLLCFG_CTRL_RST     12'h040
`define PLLCFG_DIV_RST      15'h0001
// divider limits
`define PLLCFG_FB2_MIN_SYN  10'h008
`define PLLCFG_OBASE_MAX    3'h5
`define PLLCFG_OEXP_MAX     4'hc
`define PLLCFG_OUT_CH       8
`endif

/* pllcfg_pkg.sv */
package pllcfg_pkg;
    // frequency generation modes decoded from the control word
    typedef enum logic [1:0] {
        PLLCFG_DUAL,
        PLLCFG_SYNTH,
        PLLCFG_VCXO,
        PLLCFG_BYPASS
    } pllcfg_mode_e;
endpackage : pllcfg_pkg

/* pllcfg_top.sv */
`timescale 1ns/1ps
`include "pllcfg_map.svh"
// What this block does
// RULE1 - bypass bit routes input to second loop
// RULE2 - select 10 uses first-loop oscillator as reference
// RULE3 - halving bit adds divide-by-two in feedback; the code ignores it when route 1 picks the cascade
// RULE4 - full bypass: manual input, no monitoring
// RULE5 - software sets bypass, doubler off, select 11
// RULE6 - bypass output ratio is input*pre*output divider
// RULE7 - delay units timed from select mux output
// RULE8 - input divider ratios 1, 2, 4, 8
// RULE9 - second-loop prediv seven bits, 1 to 127
// RULE10 - synth feedback divider 8 to 1023
// RULE11 - output dividers base 1-5 times 2^0-12
// RULE12 - first-loop ref and feedback dividers 15 bits
// RULE13 - auxiliary cascade divider has 14 bits
// RULE14 - doubler makes effective prediv one half
// RULE15 - route bit picks own or cascaded feedback
// RULE16 - cascade with prediv one for fixed delay
// RULE17 - centering set at start, software clears it
// RULE18 - switching and holdover need first loop active
// RULE19 - software sets guard for low reference
// RULE20 - guard invalidates loss flag, stops switching
// RULE21 - halve select divides external oscillator by two
// RULE22 - route 0 own divider, 1 both in cascade
// RULE23 - doubler on disables prediv, off it divides
// RULE24 - mode selects decoded combinationally, no reset
module pllcfg_top (
    input  wire logic        SYS_CLK_I,
    input  wire logic        NRST_I,
    input  wire logic        WB_CYC_I,
    input  wire logic        WB_STB_I,
    input  wire logic        WB_WE_I,
    input  wire logic [7:0]  WB_ADR_I,
    input  wire logic [3:0]  WB_SEL_I,
    input  wire logic [31:0] WB_DAT_I,
    output logic      [31:0] WB_DAT_O,
    output logic             WB_ACK_O,
    input  wire logic        INPUT_LOSS_RAW_I,
    input  wire logic        LOCK_RAW_I,
    output logic             SECOND_LOOP_DIRECT_O,
    output logic             SECOND_LOOP_BYPASS_O,
    output logic             FULL_BYPASS_O,
    output logic [1:0]       DELAY_REF_SEL_O,
    output logic             ACTIVE_INPUT_O,
    output logic             AUTO_SWITCH_EN_O,
    output logic             HOLDOVER_EN_O,
    output logic             LOCK_REPORT_O,
    output logic             INPUT_LOSS_FLAG_O,
    output logic             VCXO_CENTER_O,
    output logic             FIRST_LOCK_EN_O,
    output logic             EXT_OSC_HALVE_O,
    output logic             DOUBLER_EN_O,
    output logic [3:0]       IN_DIV_O,
    output logic [14:0]      REF_PREDIV_O,
    output logic [28:0]      FIRST_FB_TOTAL_O,
    output logic [6:0]       SECOND_PREDIV_O,
    output logic [9:0]       SECOND_FB_DIV_O,
    output logic [10:0]      BYPASS_PATH_DIV_O,
    output logic [119:0]     OUT_DIV_O
);

    // control word and divider settings held by software
    logic [11:0] ctrl_r;                 // mode and steering bits
    logic [14:0] ref_prediv_r;           // first_loop_ref_prediv
    logic [14:0] fb_div_r;               // first_loop_fb_div
    logic [13:0] aux_fb_r;               // aux_cascade_fb_div
    logic [6:0]  pre2_r;                 // second_loop_prediv
    logic [9:0]  fb2_r;                  // second_loop_fb_div
    logic [6:0]  outdiv_r [`PLLCFG_OUT_CH]; // base in [2:0], power in [6:3]

    // named views of the control bits
    logic        first_loop_bypass;
    logic [1:0]  ref_source_select;
    logic        first_fb_extra_halve;
    logic        second_loop_doubler_en;
    logic        first_loop_fb_route;
    logic        vcxo_center_force;
    logic        low_reference_guard;
    logic        ext_osc_halve_sel;
    logic [1:0]  in_div_code;            // log2 of input divider
    logic        manual_input_sel;

    // bus decode helpers
    logic        wb_req;                 // access pending, not yet answered
    logic        wb_wr;                  // write strobe on the answering edge
    logic [31:0] rd_nxt;                 // read data for current address
    logic        mode_ok;                // flags a half-set full bypass in status
    pllcfg_pkg::pllcfg_mode_e mode;     // decoded mode

    assign first_loop_bypass      = ctrl_r[`PLLCFG_BYPASS_BIT];
    assign ref_source_select      = ctrl_r[`PLLCFG_SRCSEL_LSB +: 2];
    assign first_fb_extra_halve   = ctrl_r[`PLLCFG_HALVE_BIT];
    assign second_loop_doubler_en = ctrl_r[`PLLCFG_DBL_BIT];
    assign first_loop_fb_route    = ctrl_r[`PLLCFG_ROUTE_BIT];
    assign vcxo_center_force      = ctrl_r[`PLLCFG_CENTER_BIT];
    assign low_reference_guard    = ctrl_r[`PLLCFG_GUARD_BIT];
    assign ext_osc_halve_sel      = ctrl_r[`PLLCFG_EXTH_BIT];
    assign in_div_code            = ctrl_r[`PLLCFG_INDIV_LSB +: 2];
    assign manual_input_sel       = ctrl_r[`PLLCFG_MANSEL_BIT];

    // merge write data into a register under the byte enables
    function automatic logic [31:0] wr_merge(
        input logic [31:0] old,
        input logic [31:0] dat,
        input logic [3:0]  sel
    );
        logic [31:0] res;
        res = old;
        for (int b = 0; b < 4; b++) begin
            if (sel[b]) begin
                res[b*8 +: 8] = dat[b*8 +: 8];
            end
        end
        return res;
    endfunction : wr_merge

    // a zero ratio is not meaningful; treat it as divide by one
    function automatic logic [14:0] no_zero(input logic [14:0] v);
        return (v == 15'h0000) ? 15'h0001 : v;
    endfunction : no_zero

    // classic wishbone: ack one cycle after the strobe, dropped next
    assign wb_req = WB_CYC_I & WB_STB_I & ~WB_ACK_O;
    assign wb_wr  = wb_req & WB_WE_I;

    // ack generation; every address answers, unmapped ones with zero
    always_ff @(posedge SYS_CLK_I or negedge NRST_I) begin
        if (!NRST_I) begin
            WB_ACK_O <= 1'b0;
        end else begin
            WB_ACK_O <= wb_req;
        end
    end

    // mode decode straight from the stored bits, so any change acts
    // at once without a reset
    always_comb begin
        if (ref_source_select == 2'h3) begin
            mode = pllcfg_pkg::PLLCFG_BYPASS;             // RULE24
        end else if (ref_source_select == 2'h2) begin
            mode = pllcfg_pkg::PLLCFG_VCXO;               // RULE2
        end else if (first_loop_bypass) begin
            mode = pllcfg_pkg::PLLCFG_SYNTH;              // RULE1
        end else begin
            mode = pllcfg_pkg::PLLCFG_DUAL;
        end
    end

    // full bypass follows select 11 alone, whatever the bypass and doubler bits;
    // a half-set bypass is flagged in status rather than corrected
    assign mode_ok = (mode != pllcfg_pkg::PLLCFG_BYPASS)
                   | (first_loop_bypass & ~second_loop_doubler_en); // RULE5

    // control register; centering forced at start-up
    always_ff @(posedge SYS_CLK_I or negedge NRST_I) begin
        if (!NRST_I) begin
            ctrl_r <= `PLLCFG_CTRL_RST;                    // RULE17
        end else if (wb_wr && WB_ADR_I == `PLLCFG_CTRL_OFS) begin
            // a cast keeps the low bits; a function result cannot be sliced
            ctrl_r <= 12'(wr_merge({20'h00000, ctrl_r}, WB_DAT_I, WB_SEL_I));
        end
    end

    // first-loop dividers, widths fixed by the hardware
    always_ff @(posedge SYS_CLK_I or negedge NRST_I) begin
        if (!NRST_I) begin
            ref_prediv_r <= `PLLCFG_DIV_RST;
            fb_div_r     <= `PLLCFG_DIV_RST;
            aux_fb_r     <= 14'h0001;
        end else if (wb_wr) begin
            case (WB_ADR_I)
                `PLLCFG_REFDIV_OFS: begin                  // RULE12
                    ref_prediv_r <= 15'(wr_merge({17'h00000, ref_prediv_r},
                                    WB_DAT_I, WB_SEL_I));
                end
                `PLLCFG_FBDIV_OFS: begin                   // RULE12
                    fb_div_r <= 15'(wr_merge({17'h00000, fb_div_r},
                                WB_DAT_I, WB_SEL_I));
                end
                `PLLCFG_AUXFB_OFS: begin                   // RULE13
                    aux_fb_r <= 14'(wr_merge({18'h00000, aux_fb_r},
                                WB_DAT_I, WB_SEL_I));
                end
                default: begin
                end
            endcase
        end
    end

    // second-loop dividers
    always_ff @(posedge SYS_CLK_I or negedge NRST_I) begin
        if (!NRST_I) begin
            pre2_r <= 7'h01;
            fb2_r  <= `PLLCFG_FB2_MIN_SYN;
        end else if (wb_wr) begin
            case (WB_ADR_I)
                `PLLCFG_PRE2_OFS: begin                    // RULE9
                    pre2_r <= 7'(wr_merge({25'h0000000, pre2_r},
                              WB_DAT_I, WB_SEL_I));
                end
                `PLLCFG_FB2_OFS: begin                     // RULE10
                    fb2_r <= 10'(wr_merge({22'h000000, fb2_r},
                             WB_DAT_I, WB_SEL_I));
                end
                default: begin
                end
            endcase
        end
    end

    // eight output channel dividers, one word each
    for (genvar ch = 0; ch < `PLLCFG_OUT_CH; ch++) begin : g_out
        logic [7:0]  ofs;                // this channel's byte offset
        logic [2:0]  base;               // base clamped to 1..5
        logic [3:0]  pwr;                // power clamped to 0..12
        assign ofs = 8'(`PLLCFG_OUTDIV_OFS + 4 * ch);

        always_ff @(posedge SYS_CLK_I or negedge NRST_I) begin
            if (!NRST_I) begin
                outdiv_r[ch] <= 7'h01;
            end else if (wb_wr && WB_ADR_I == ofs && WB_SEL_I[0]) begin
                outdiv_r[ch] <= WB_DAT_I[6:0];
            end
        end

        // out-of-range codes saturate rather than wrap
        always_comb begin
            if (outdiv_r[ch][2:0] == 3'h0) begin
                base = 3'h1;                               // RULE11
            end else if (outdiv_r[ch][2:0] > `PLLCFG_OBASE_MAX) begin
                base = `PLLCFG_OBASE_MAX;
            end else begin
                base = outdiv_r[ch][2:0];
            end
            if (outdiv_r[ch][6:3] > `PLLCFG_OEXP_MAX) begin
                pwr = `PLLCFG_OEXP_MAX;
            end else begin
                pwr = outdiv_r[ch][6:3];
            end
        end

        // ratio register, at most 5 * 4096 = 20480
        always_ff @(posedge SYS_CLK_I or negedge NRST_I) begin
            if (!NRST_I) begin
                OUT_DIV_O[ch*15 +: 15] <= 15'h0001;
            end else begin
                OUT_DIV_O[ch*15 +: 15] <= 15'(base) << pwr; // RULE11
            end
        end
    end

    // register read mux
    always_comb begin
        rd_nxt = 32'h00000000;
        case (WB_ADR_I)
            `PLLCFG_CTRL_OFS:   rd_nxt = {20'h00000, ctrl_r};
            `PLLCFG_REFDIV_OFS: rd_nxt = {17'h00000, ref_prediv_r};
            `PLLCFG_FBDIV_OFS:  rd_nxt = {17'h00000, fb_div_r};
            `PLLCFG_AUXFB_OFS:  rd_nxt = {18'h00000, aux_fb_r};
            `PLLCFG_PRE2_OFS:   rd_nxt = {25'h0000000, pre2_r};
            `PLLCFG_FB2_OFS:    rd_nxt = {22'h000000, fb2_r};
            `PLLCFG_STAT_OFS: begin
                // live state of the block
                rd_nxt = {24'h000000, AUTO_SWITCH_EN_O, HOLDOVER_EN_O,
                          FIRST_LOCK_EN_O, INPUT_LOSS_FLAG_O,
                          LOCK_REPORT_O, mode_ok, 2'(mode)};
            end
            default: begin
                for (int c = 0; c < `PLLCFG_OUT_CH; c++) begin
                    if (WB_ADR_I == 8'(`PLLCFG_OUTDIV_OFS + 4 * c)) begin
                        rd_nxt = {25'h0000000, outdiv_r[c]};
                    end
                end
            end
        endcase
    end

    // read data registered with the ack
    always_ff @(posedge SYS_CLK_I or negedge NRST_I) begin
        if (!NRST_I) begin
            WB_DAT_O <= 32'h00000000;
        end else if (wb_req && !WB_WE_I) begin
            WB_DAT_O <= rd_nxt;
        end
    end

    // path selects are plain decodes so that software sees them
    // change in the same cycle as the write lands
    assign SECOND_LOOP_DIRECT_O = first_loop_bypass;        // RULE1
    assign SECOND_LOOP_BYPASS_O = (mode == pllcfg_pkg::PLLCFG_VCXO); // RULE2
    assign FULL_BYPASS_O = (mode == pllcfg_pkg::PLLCFG_BYPASS); // RULE24
    assign DELAY_REF_SEL_O = ref_source_select;             // RULE7
    assign EXT_OSC_HALVE_O = ext_osc_halve_sel;             // RULE21
    assign DOUBLER_EN_O = second_loop_doubler_en;           // RULE14
    assign VCXO_CENTER_O = vcxo_center_force;               // RULE17

    // first loop can lock only once centering is released and the
    // loop is in the signal path
    assign FIRST_LOCK_EN_O = ~vcxo_center_force & ~first_loop_bypass
                           & ~FULL_BYPASS_O;                // RULE17

    // holdover and switching need the first loop in the path
    assign HOLDOVER_EN_O = ~first_loop_bypass & ~FULL_BYPASS_O; // RULE18

    // guard bit invalidates loss detect and stops auto switching
    assign AUTO_SWITCH_EN_O = HOLDOVER_EN_O & ~low_reference_guard; // RULE20

    // no monitoring at all in full bypass
    assign INPUT_LOSS_FLAG_O = INPUT_LOSS_RAW_I & ~FULL_BYPASS_O
                             & ~low_reference_guard;        // RULE4
    assign LOCK_REPORT_O = LOCK_RAW_I & ~FULL_BYPASS_O;     // RULE4

    // only the manual select picks the input in bypass; elsewhere
    // the manual choice is still the starting input
    assign ACTIVE_INPUT_O = manual_input_sel;               // RULE4

    // effective ratios, registered since they fan out widely
    always_ff @(posedge SYS_CLK_I or negedge NRST_I) begin
        if (!NRST_I) begin
            IN_DIV_O     <= 4'h1;
            REF_PREDIV_O <= 15'h0001;
        end else begin
            IN_DIV_O     <= 4'h1 << in_div_code;            // RULE8
            REF_PREDIV_O <= no_zero(ref_prediv_r);          // RULE12
        end
    end

    // first-loop feedback: own divider (optionally halved) or the
    // cascade through the second loop
    always_ff @(posedge SYS_CLK_I or negedge NRST_I) begin
        if (!NRST_I) begin
            FIRST_FB_TOTAL_O <= 29'h00000001;
        end else if (first_loop_fb_route) begin             // RULE15
            FIRST_FB_TOTAL_O <= 29'(no_zero(fb_div_r))
                * 29'(no_zero({1'b0, aux_fb_r}));           // RULE22
        end else if (first_fb_extra_halve) begin
            FIRST_FB_TOTAL_O <= 29'(no_zero(fb_div_r)) << 1; // RULE3
        end else begin
            FIRST_FB_TOTAL_O <= 29'(no_zero(fb_div_r));     // RULE22
        end
    end

    // second-loop pre-division: zero when the doubler bypasses it
    always_ff @(posedge SYS_CLK_I or negedge NRST_I) begin
        if (!NRST_I) begin
            SECOND_PREDIV_O <= 7'h01;
        end else if (second_loop_doubler_en) begin
            SECOND_PREDIV_O <= 7'h00;                       // RULE23
        end else if (pre2_r == 7'h00) begin
            SECOND_PREDIV_O <= 7'h01;                       // RULE9
        end else begin
            SECOND_PREDIV_O <= pre2_r;                      // RULE23
        end
    end

    // second-loop feedback; the synthesizer needs at least 8
    always_ff @(posedge SYS_CLK_I or negedge NRST_I) begin
        if (!NRST_I) begin
            SECOND_FB_DIV_O <= `PLLCFG_FB2_MIN_SYN;
        end else if (mode == pllcfg_pkg::PLLCFG_SYNTH
                     && fb2_r < `PLLCFG_FB2_MIN_SYN) begin
            SECOND_FB_DIV_O <= `PLLCFG_FB2_MIN_SYN;         // RULE10
        end else if (fb2_r == 10'h000) begin
            SECOND_FB_DIV_O <= 10'h001;
        end else begin
            SECOND_FB_DIV_O <= fb2_r;
        end
    end

    // bypass fanout: input divider times prediv, output divider
    // applied per channel; doubler must be off so prediv is real
    always_ff @(posedge SYS_CLK_I or negedge NRST_I) begin
        if (!NRST_I) begin
            BYPASS_PATH_DIV_O <= 11'h001;
        end else begin
            BYPASS_PATH_DIV_O <= 11'(4'h1 << in_div_code)
                * 11'((pre2_r == 7'h00) ? 7'h01 : pre2_r); // RULE6
        end
    end

endmodule : pllcfg_top

/* pllcfg_top_checker.sv */
`timescale 1ns/1ps
// watches only the top ports; combinational mode outputs are tied to their causes
module pllcfg_checker (
    input wire logic        SYS_CLK_I,
    input wire logic        NRST_I,
    input wire logic        WB_CYC_I,
    input wire logic        WB_STB_I,
    input wire logic        WB_WE_I,
    input wire logic [7:0]  WB_ADR_I,
    input wire logic [3:0]  WB_SEL_I,
    input wire logic [31:0] WB_DAT_I,
    input wire logic        WB_ACK_O,
    input wire logic        LOCK_RAW_I,
    input wire logic        INPUT_LOSS_RAW_I,
    input wire logic        SECOND_LOOP_DIRECT_O,
    input wire logic        SECOND_LOOP_BYPASS_O,
    input wire logic        FULL_BYPASS_O,
    input wire logic [1:0]  DELAY_REF_SEL_O,
    input wire logic        AUTO_SWITCH_EN_O,
    input wire logic        HOLDOVER_EN_O,
    input wire logic        LOCK_REPORT_O,
    input wire logic        INPUT_LOSS_FLAG_O,
    input wire logic        VCXO_CENTER_O,
    input wire logic        FIRST_LOCK_EN_O,
    input wire logic        DOUBLER_EN_O,
    input wire logic [3:0]  IN_DIV_O,
    input wire logic [6:0]  SECOND_PREDIV_O
);
    // one domain, so one clock and one reset for every property
    default clocking cb @(posedge SYS_CLK_I); endclocking
    default disable iff (!NRST_I);

    // a control write shows on the mode selects at the acknowledging edge
    ctrl_write_a: assert property ((WB_ACK_O && WB_WE_I && WB_ADR_I == 8'h00 && WB_SEL_I[0])
        |-> SECOND_LOOP_DIRECT_O == WB_DAT_I[0] && DELAY_REF_SEL_O == WB_DAT_I[2:1])
        else $error("control write not reflected on mode selects");
    vcxo_mode_a: assert property (SECOND_LOOP_BYPASS_O == (DELAY_REF_SEL_O == 2'h2))
        else $error("second loop bypass does not follow select 10");
    bypass_mon_a: assert property (FULL_BYPASS_O
        |-> !LOCK_REPORT_O && !INPUT_LOSS_FLAG_O && !AUTO_SWITCH_EN_O)
        else $error("monitoring active in full bypass");
    lock_pass_a: assert property (!FULL_BYPASS_O |-> LOCK_REPORT_O == LOCK_RAW_I)
        else $error("lock report does not follow raw lock");
    loss_cause_a: assert property (INPUT_LOSS_FLAG_O |-> INPUT_LOSS_RAW_I)
        else $error("loss flag without raw loss");
    synth_hold_a: assert property (SECOND_LOOP_DIRECT_O
        |-> !HOLDOVER_EN_O && !AUTO_SWITCH_EN_O)
        else $error("holdover or switching with first loop bypassed");
    center_lock_a: assert property (VCXO_CENTER_O |-> !FIRST_LOCK_EN_O)
        else $error("first loop lock enabled while centering");
    dbl_prediv_a: assert property ($past(DOUBLER_EN_O) |-> SECOND_PREDIV_O == 7'h00)
        else $error("prediv active with doubler on");
    in_div_a: assert property (IN_DIV_O inside {4'h1, 4'h2, 4'h4, 4'h8})
        else $error("input divider ratio out of set");
    ack_resp_a: assert property ((WB_CYC_I && WB_STB_I && !WB_ACK_O) |=> WB_ACK_O ##1 !WB_ACK_O)
        else $error("bus answer not a one cycle ack");
endmodule : pllcfg_checker

/* pllcfg_top_tb.sv */
`timescale 1ns/1ps
module pllcfg_top_tb;
    logic         SYS_CLK_I = 1'b0;
    logic         NRST_I = 1'b0;
    logic         WB_CYC_I = 1'b0, WB_STB_I = 1'b0, WB_WE_I = 1'b0;
    logic [7:0]   WB_ADR_I = 8'h00;
    logic [3:0]   WB_SEL_I = 4'h0;
    logic [31:0]  WB_DAT_I = 32'h0, WB_DAT_O;
    logic         WB_ACK_O;
    logic         INPUT_LOSS_RAW_I = 1'b1, LOCK_RAW_I = 1'b1;
    logic         SECOND_LOOP_DIRECT_O, SECOND_LOOP_BYPASS_O, FULL_BYPASS_O;
    logic [1:0]   DELAY_REF_SEL_O;
    logic         ACTIVE_INPUT_O, AUTO_SWITCH_EN_O, HOLDOVER_EN_O, LOCK_REPORT_O;
    logic         INPUT_LOSS_FLAG_O, VCXO_CENTER_O, FIRST_LOCK_EN_O;
    logic         EXT_OSC_HALVE_O, DOUBLER_EN_O;
    logic [3:0]   IN_DIV_O;
    logic [14:0]  REF_PREDIV_O;
    logic [28:0]  FIRST_FB_TOTAL_O;
    logic [6:0]   SECOND_PREDIV_O;
    logic [9:0]   SECOND_FB_DIV_O;
    logic [10:0]  BYPASS_PATH_DIV_O;
    logic [119:0] OUT_DIV_O;
    int           bad_count = 0;
    int           compares = 0;
    logic [31:0]  rdat;

    // 40 MHz system clock
    always #12.5 SYS_CLK_I = ~SYS_CLK_I;

    pllcfg_top u_dut (.*);

    // prints the counts and the verdict, then stops the run
    task automatic test_done;
        $display("compares %0d mismatches %0d", compares, bad_count);
        if (bad_count == 0 && compares > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : test_done

    // case equality so an unknown never passes
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            bad_count++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    // classic single cycle; hold until ack is sampled high, then release
    task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d);
        @(posedge SYS_CLK_I);
        WB_CYC_I <= 1'b1;
        WB_STB_I <= 1'b1;
        WB_WE_I  <= we;
        WB_ADR_I <= a;
        WB_SEL_I <= 4'hf;
        WB_DAT_I <= d;
        do @(posedge SYS_CLK_I); while (WB_ACK_O !== 1'b1);
        rdat = WB_DAT_O;
        WB_CYC_I <= 1'b0;
        WB_STB_I <= 1'b0;
        WB_WE_I  <= 1'b0;
        // registered ratios land at this edge; look once they settle
        @(negedge SYS_CLK_I);
    endtask : wb

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        wb(1'b1, a, d);
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        wb(1'b0, a, 32'h0);
        chk(rdat, exp);
    endtask : rd

    // cuts a hang short; the whole sequence needs well under a thousand cycles
    initial begin
        repeat (5000) @(posedge SYS_CLK_I);
        bad_count++;
        test_done();
    end

    initial begin
        repeat (4) @(posedge SYS_CLK_I);
        NRST_I <= 1'b1;
        rd(8'h00, 32'h040);
        chk(VCXO_CENTER_O, 1);
        chk(FIRST_LOCK_EN_O, 0);
        wr(8'h00, 32'h000);
        chk(FIRST_LOCK_EN_O, 1);
        chk({LOCK_REPORT_O, INPUT_LOSS_FLAG_O, AUTO_SWITCH_EN_O}, 3'h7);
        // raw monitors pass through outside bypass; toggle each one alone
        @(posedge SYS_CLK_I);
        {INPUT_LOSS_RAW_I, LOCK_RAW_I} <= 2'b10;
        @(negedge SYS_CLK_I);
        chk({LOCK_REPORT_O, INPUT_LOSS_FLAG_O}, 2'h1);
        @(posedge SYS_CLK_I);
        {INPUT_LOSS_RAW_I, LOCK_RAW_I} <= 2'b01;
        @(negedge SYS_CLK_I);
        chk({LOCK_REPORT_O, INPUT_LOSS_FLAG_O}, 2'h2);
        @(posedge SYS_CLK_I);
        {INPUT_LOSS_RAW_I, LOCK_RAW_I} <= 2'b11;
        wr(8'h00, 32'h080);
        chk({INPUT_LOSS_FLAG_O, AUTO_SWITCH_EN_O, HOLDOVER_EN_O}, 3'h1);
        wr(8'h00, 32'h001);
        chk({SECOND_LOOP_DIRECT_O, HOLDOVER_EN_O, FIRST_LOCK_EN_O}, 3'h4);
        wr(8'h14, 32'h003);
        chk(SECOND_FB_DIV_O, 10'h008);
        wr(8'h14, 32'h3ff);
        chk(SECOND_FB_DIV_O, 10'h3ff);
        wr(8'h00, 32'h004);
        chk({SECOND_LOOP_BYPASS_O, DELAY_REF_SEL_O}, 3'h6);
        // full bypass: input divider 8, prediv 5, manual input 1
        wr(8'h10, 32'h005);
        wr(8'h00, 32'he07);
        chk({FULL_BYPASS_O, LOCK_REPORT_O, INPUT_LOSS_FLAG_O}, 3'h4);
        chk({AUTO_SWITCH_EN_O, HOLDOVER_EN_O, ACTIVE_INPUT_O}, 3'h1);
        chk(DELAY_REF_SEL_O, 2'h3);
        chk(BYPASS_PATH_DIV_O, 11'd40);
        rd(8'h18, 32'h07);
        // select 11 without the bypass bit is flagged as a bad mode
        wr(8'h00, 32'h006);
        rd(8'h18, 32'h03);
        for (int c = 0; c < 4; c++) begin
            wr(8'h00, 32'(c) << 9);
            chk(IN_DIV_O, 32'h1 << c);
        end
        wr(8'h08, 32'h003);
        wr(8'h0c, 32'h005);
        wr(8'h10, 32'h001);
        wr(8'h00, 32'h020);
        chk(FIRST_FB_TOTAL_O, 29'd15);
        wr(8'h00, 32'h008);
        chk(FIRST_FB_TOTAL_O, 29'd6);
        wr(8'h00, 32'h000);
        chk(FIRST_FB_TOTAL_O, 29'd3);
        wr(8'h08, 32'h001);
        wr(8'h0c, 32'h3fff);
        wr(8'h00, 32'h020);
        chk(FIRST_FB_TOTAL_O, 29'h3fff);
        wr(8'h04, 32'h7fff);
        chk(REF_PREDIV_O, 15'h7fff);
        wr(8'h08, 32'h7fff);
        wr(8'h00, 32'h000);
        chk(FIRST_FB_TOTAL_O, 29'h7fff);
        wr(8'h10, 32'h07f);
        chk(SECOND_PREDIV_O, 7'h7f);
        wr(8'h00, 32'h010);
        chk({DOUBLER_EN_O, SECOND_PREDIV_O}, 8'h80);
        wr(8'h00, 32'h100);
        chk(EXT_OSC_HALVE_O, 1);
        // output dividers: largest legal, saturated codes, smallest
        wr(8'h2c, 32'h065);
        chk(OUT_DIV_O[45+:15], 15'd20480);
        wr(8'h20, 32'h07f);
        chk(OUT_DIV_O[0+:15], 15'd20480);
        wr(8'h3c, 32'h001);
        chk(OUT_DIV_O[105+:15], 15'd1);
        rd(8'h1c, 32'h0);
        test_done();
    end
endmodule : pllcfg_top_tb

bind pllcfg_top pllcfg_checker u_chk (
    .SYS_CLK_I(SYS_CLK_I), .NRST_I(NRST_I), .WB_CYC_I(WB_CYC_I), .WB_STB_I(WB_STB_I),
    .WB_WE_I(WB_WE_I), .WB_ADR_I(WB_ADR_I), .WB_SEL_I(WB_SEL_I), .WB_DAT_I(WB_DAT_I),
    .WB_ACK_O(WB_ACK_O), .LOCK_RAW_I(LOCK_RAW_I), .INPUT_LOSS_RAW_I(INPUT_LOSS_RAW_I),
    .SECOND_LOOP_DIRECT_O(SECOND_LOOP_DIRECT_O), .SECOND_LOOP_BYPASS_O(SECOND_LOOP_BYPASS_O),
    .FULL_BYPASS_O(FULL_BYPASS_O), .DELAY_REF_SEL_O(DELAY_REF_SEL_O),
    .AUTO_SWITCH_EN_O(AUTO_SWITCH_EN_O), .HOLDOVER_EN_O(HOLDOVER_EN_O),
    .LOCK_REPORT_O(LOCK_REPORT_O), .INPUT_LOSS_FLAG_O(INPUT_LOSS_FLAG_O),
    .VCXO_CENTER_O(VCXO_CENTER_O), .FIRST_LOCK_EN_O(FIRST_LOCK_EN_O),
    .DOUBLER_EN_O(DOUBLER_EN_O), .IN_DIV_O(IN_DIV_O), .SECOND_PREDIV_O(SECOND_PREDIV_O));
